/* File: pkg/eep_pkg.sv */
// constants and types for the two-wire serial eeprom slave front end
// assumes a 125 mhz core clock and a separate link sampling clock
package eep_pkg;

  // array organisation
  localparam int MEM_DEPTH = 2048;
  localparam int ADDR_W = 11;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_W = 4;

  // self-timed programming cycle, longest time rounds down
  localparam int PROG_TIME_NS = 5000000;
  localparam int CORE_PERIOD_NS = 8;
  localparam int PROG_CYCLES = PROG_TIME_NS / CORE_PERIOD_NS;
  localparam int PROG_CNT_W = 20;

  // glitch filter depth in link samples
  localparam int FILT_LEN_DEF = 3;

  // address byte field positions
  localparam int DIR_BIT = 0;
  localparam int BLK_LSB = 1;
  localparam int TYPE_LSB = 4;

  // counts and reset values
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [ADDR_W-1:0] PTR_RST = 11'h000;
  localparam logic [PAGE_BYTES-1:0] MASK_RST = 16'h0000;
  localparam logic [PAGE_W-1:0] LAST_IDX = 4'hf;

  // protocol engine states
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_DEV = 6'h02,
    S_WORD = 6'h04,
    S_WDATA = 6'h08,
    S_READ = 6'h10,
    S_IGN = 6'h20
  } eep_state_type;

endpackage

/* File: core/eep_two_wire_slave.sv */
// two-wire serial eeprom slave: protocol engine, page buffer, array and
// self-timed programming cycle. assumes open-drain bus resolved outside,
// link_clk_in oversampling the bus and the core clock timing programming.
// How it works
// - array holds 2048 bytes, grouped in 16-byte pages for writing
// - programming is self-timed and finishes within 5 ms
// - partial page writes program only bytes actually received
// - protect input high blocks every change to the array
// - protect input low or open allows normal programming
// - during power-on reset bus ignored, then state machine to standby
// - after stop return to standby only once programming has ended
// - device select inputs never affect the bus address
// - sda is only pulled low or released, never driven high
// - an sda change while scl high is start or stop, never data
// - sda changes only while scl low; one scl pulse per bit
// - start is sda falling while scl high and precedes every command
// - stay passive, driving nothing, until a valid start
// - correct operation for scl up to 1 mhz
// - stop is sda rising while scl high; every operation ends so
// - the receiver acknowledges by pulling sda low on pulse nine
// - address byte: type code, three block bits, direction bit
// - direction bit 1 means read, 0 means write
`timescale 1ns/1ps
`default_nettype none

module eep_two_wire_slave
  import eep_pkg::*;
#(
  parameter int PROG_CYCLES_P = PROG_CYCLES,
  parameter logic [3:0] DEV_CODE = 4'h5, // arbitrary type code value
  parameter int FILT_LEN = FILT_LEN_DEF
) (
  input wire logic core_clk_in, // 125 mhz core clock
  input wire logic rst_n_in, // power-on reset, sync, active low
  input wire logic link_clk_in, // bus sampling clock
  input wire logic scl_in, // serial clock pin level
  input wire logic sda_in, // serial data pin level
  output logic sda_out, // sda output value, always low
  output logic sda_oe_out, // high while pulling sda low
  input wire logic wp_in, // write protect, high protects
  input wire logic [2:0] device_select_inputs_in, // not connected inside
  output logic busy_out, // programming cycle running
  output logic standby_out // bus idle and not programming
);

  // refuse settings the logic cannot serve
  if (FILT_LEN < 1 || FILT_LEN > 8) begin : g_chk_filt
    $error("filter length out of range");
  end
  if (PROG_CYCLES_P < 1 || PROG_CYCLES_P >= (1 << PROG_CNT_W)) begin : g_chk_prog
    $error("programming count out of range");
  end

  // ---------------- link domain ----------------
  logic lrst_s1_reg;
  logic lrst_n_reg;
  logic wp_s1_reg;
  logic wp_s2_reg;
  wire [1:0] filt;
  logic scl_q_reg;
  logic sda_q_reg;
  logic dn_s1_reg;
  logic dn_s2_reg;
  logic done_tog_reg; // core domain, read here only through dn_s1_reg
  logic req_tog_reg;
  logic idle_lvl_reg;
  eep_state_type state_reg;
  eep_state_type nxt_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic ack_ph_reg;
  logic sda_oe_reg;
  logic nack_reg;
  logic [ADDR_W-1:0] ptr_reg;
  logic [2:0] blk_reg;
  logic [ADDR_W-PAGE_W-1:0] page_reg;
  logic [PAGE_BYTES-1:0] mask_reg;
  logic commit_reg;
  logic [PAGE_W-1:0] cidx_reg;
  logic [7:0] pbuf [PAGE_BYTES];
  logic [7:0] mem [MEM_DEPTH];

  // reset release into the link domain; engine held idle meanwhile
  always_ff @(posedge link_clk_in) begin
    lrst_s1_reg <= rst_n_in;
    lrst_n_reg <= lrst_s1_reg;
  end

  // pin synchronisers and agreement filter, idle bus reads high
  wire [1:0] pins_raw = {scl_in, sda_in};
  for (genvar i = 0; i < 2; i++) begin : g_line
    logic s1_reg;
    logic s2_reg;
    logic [FILT_LEN-1:0] hist_reg;
    logic line_reg;
    always_ff @(posedge link_clk_in) begin
      s1_reg <= pins_raw[i];
      s2_reg <= s1_reg;
      if (!lrst_n_reg) begin
        hist_reg <= '1;
        line_reg <= 1'b1;
      end else begin
        hist_reg <= {hist_reg[FILT_LEN-2+(FILT_LEN==1):0], s2_reg};
        if (&hist_reg) line_reg <= 1'b1;
        else if (~|hist_reg) line_reg <= 1'b0;
      end
    end
    assign filt[i] = line_reg;
  end
  wire scl_f = filt[1];
  wire sda_f = filt[0];

  // protect pin and done toggle crossings
  always_ff @(posedge link_clk_in) begin
    wp_s1_reg <= wp_in;
    wp_s2_reg <= wp_s1_reg;
    dn_s1_reg <= done_tog_reg;
    dn_s2_reg <= dn_s1_reg;
  end

  // line events; only changes during scl high are start or stop
  wire scl_rise = scl_f & ~scl_q_reg;
  wire scl_fall = ~scl_f & scl_q_reg;
  wire start_det = scl_f & scl_q_reg & sda_q_reg & ~sda_f;
  wire stop_det = scl_f & scl_q_reg & ~sda_q_reg & sda_f;

  // byte framing decode
  wire link_busy = req_tog_reg ^ dn_s2_reg;
  wire rx_st = (state_reg == S_DEV) | (state_reg == S_WORD) | (state_reg == S_WDATA);
  wire byte_done = scl_fall & rx_st & ~ack_ph_reg & (bit_cnt_reg == BYTE_BITS);
  wire ack_end = scl_fall & ack_ph_reg;
  // select pins unused: address depends only on the type code
  wire dev_match = (shift_reg[7:TYPE_LSB] == DEV_CODE) & ~link_busy & ~commit_reg;
  wire do_ack = (state_reg == S_DEV) ? dev_match : 1'b1;
  wire is_rd = shift_reg[DIR_BIT];
  wire [5:0] dev_nxt = ~dev_match ? S_IGN : is_rd ? S_READ : S_WORD;
  wire [5:0] rx_nxt = (state_reg == S_DEV) ? dev_nxt : S_WDATA;
  wire go_read = (state_reg == S_READ) ? ~nack_reg : (nxt_reg == S_READ);
  wire [7:0] rd_byte = mem[ptr_reg];
  wire [ADDR_W-1:0] ptr_inc = ptr_reg + 11'h001;
  wire [ADDR_W-1:0] page_inc = {ptr_reg[ADDR_W-1:PAGE_W], ptr_reg[PAGE_W-1:0] + 4'h1};
  wire wr_byte = byte_done & (state_reg == S_WDATA);
  wire commit_go = stop_det & (|mask_reg) & ~wp_s2_reg & ~commit_reg;

  // protocol engine
  always_ff @(posedge link_clk_in) begin
    if (!lrst_n_reg) begin
      state_reg <= S_IDLE;
      nxt_reg <= S_IDLE;
      bit_cnt_reg <= BIT_CNT_RST;
      shift_reg <= 8'h00;
      ack_ph_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      nack_reg <= 1'b0;
      ptr_reg <= PTR_RST;
      blk_reg <= 3'h0;
      page_reg <= '0;
      mask_reg <= MASK_RST;
      commit_reg <= 1'b0;
      cidx_reg <= '0;
      req_tog_reg <= 1'b0;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      idle_lvl_reg <= 1'b0;
    end else begin
      scl_q_reg <= scl_f;
      sda_q_reg <= sda_f;
      idle_lvl_reg <= (state_reg == S_IDLE) & ~link_busy & ~commit_reg;
      if (commit_reg) begin
        cidx_reg <= cidx_reg + 4'h1;
        if (cidx_reg == LAST_IDX) begin
          commit_reg <= 1'b0;
          mask_reg <= MASK_RST;
        end
      end
      if (start_det) begin
        state_reg <= S_DEV;
        bit_cnt_reg <= BIT_CNT_RST;
        ack_ph_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
      end else if (stop_det) begin
        state_reg <= S_IDLE;
        ack_ph_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
        if (commit_go) begin
          commit_reg <= 1'b1;
          cidx_reg <= '0;
          req_tog_reg <= ~req_tog_reg;
        end else if (!commit_reg) begin
          mask_reg <= MASK_RST;
        end
      end else if (scl_rise && (rx_st || state_reg == S_READ)) begin
        if (ack_ph_reg) begin
          nack_reg <= sda_f;
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (rx_st) shift_reg <= {shift_reg[6:0], sda_f};
        end
      end else if (byte_done) begin
        ack_ph_reg <= 1'b1;
        sda_oe_reg <= do_ack;
        nxt_reg <= eep_state_type'(rx_nxt);
        if (state_reg == S_DEV) blk_reg <= shift_reg[TYPE_LSB-1:BLK_LSB];
        if (state_reg == S_WORD) begin
          ptr_reg <= {blk_reg, shift_reg};
          mask_reg <= MASK_RST;
        end
        if (wr_byte) begin
          mask_reg[ptr_reg[PAGE_W-1:0]] <= 1'b1;
          page_reg <= ptr_reg[ADDR_W-1:PAGE_W];
          ptr_reg <= page_inc;
        end
      end else if (ack_end) begin
        ack_ph_reg <= 1'b0;
        bit_cnt_reg <= BIT_CNT_RST;
        state_reg <= go_read ? S_READ : ((state_reg == S_READ) ? S_IGN : nxt_reg);
        shift_reg <= rd_byte;
        sda_oe_reg <= go_read & ~rd_byte[7];
      end else if (scl_fall && state_reg == S_READ) begin
        if (bit_cnt_reg == BYTE_BITS) begin
          sda_oe_reg <= 1'b0; // master acknowledge slot
          ack_ph_reg <= 1'b1;
          ptr_reg <= ptr_inc;
        end else if (bit_cnt_reg != BIT_CNT_RST) begin
          shift_reg <= {shift_reg[6:0], 1'b0};
          sda_oe_reg <= ~shift_reg[6];
        end
      end
    end
  end

  // page buffer capture
  always_ff @(posedge link_clk_in) begin
    if (wr_byte) pbuf[ptr_reg[PAGE_W-1:0]] <= shift_reg;
  end

  // array update, received bytes only, one per cycle
  wire mem_we = commit_reg & mask_reg[cidx_reg];
  always_ff @(posedge link_clk_in) begin
    if (mem_we) mem[{page_reg, cidx_reg}] <= pbuf[cidx_reg];
  end

  // open-drain pin: value fixed low, enable pulls
  assign sda_out = 1'b0;
  assign sda_oe_out = sda_oe_reg;

  // ---------------- core domain ----------------
  logic rq_s1_reg;
  logic rq_s2_reg;
  logic rq_s3_reg;
  logic id_s1_reg;
  logic id_s2_reg;
  logic busy_reg;
  // done toggle flips once per finished cycle, echoed back to the link side
  logic standby_reg;
  logic [PROG_CNT_W-1:0] prog_cnt_reg;

  // programming request crossing and self timer
  wire prog_start = rq_s2_reg ^ rq_s3_reg;
  wire prog_last = prog_cnt_reg == PROG_CNT_W'(PROG_CYCLES_P - 1);
  always_ff @(posedge core_clk_in) begin
    rq_s1_reg <= req_tog_reg;
    rq_s2_reg <= rq_s1_reg;
    id_s1_reg <= idle_lvl_reg;
    id_s2_reg <= id_s1_reg;
    if (!rst_n_in) begin
      rq_s3_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_tog_reg <= 1'b0;
      prog_cnt_reg <= '0;
      standby_reg <= 1'b0;
    end else begin
      rq_s3_reg <= rq_s2_reg;
      standby_reg <= id_s2_reg & ~busy_reg & ~prog_start;
      if (prog_start) begin
        busy_reg <= 1'b1;
        prog_cnt_reg <= '0;
      end else if (busy_reg) begin
        prog_cnt_reg <= prog_cnt_reg + 1'b1;
        if (prog_last) begin
          busy_reg <= 1'b0;
          done_tog_reg <= ~done_tog_reg;
        end
      end
    end
  end
  assign busy_out = busy_reg;
  assign standby_out = standby_reg;

  // ---------------- checks ----------------
  a_idle_passive: assert property (@(posedge link_clk_in) disable iff (!lrst_n_reg)
    (state_reg == S_IDLE || state_reg == S_IGN) && !ack_ph_reg |-> !sda_oe_reg)
    else $error("sda pulled while passive");
  a_pull_scl_low: assert property (@(posedge link_clk_in) disable iff (!lrst_n_reg)
    $rose(sda_oe_reg) |-> !scl_f)
    else $error("sda pulled while scl high");
  a_start_enters: assert property (@(posedge link_clk_in) disable iff (!lrst_n_reg)
    start_det |=> state_reg == S_DEV && bit_cnt_reg == BIT_CNT_RST)
    else $error("start not taken");
  a_stop_enters: assert property (@(posedge link_clk_in) disable iff (!lrst_n_reg)
    stop_det |=> state_reg == S_IDLE && !sda_oe_reg)
    else $error("stop not taken");
  a_ack_ninth: assert property (@(posedge link_clk_in) disable iff (!lrst_n_reg)
    byte_done && state_reg != S_DEV |=> sda_oe_reg && ack_ph_reg)
    else $error("received byte not acknowledged");
  a_busy_no_ack: assert property (@(posedge link_clk_in) disable iff (!lrst_n_reg)
    byte_done && state_reg == S_DEV && link_busy |=> !sda_oe_reg)
    else $error("address acknowledged while programming");
  a_read_dir: assert property (@(posedge link_clk_in) disable iff (!lrst_n_reg)
    byte_done && state_reg == S_DEV && dev_match && is_rd |=> nxt_reg == S_READ)
    else $error("read direction not decoded");
  a_page_kept: assert property (@(posedge link_clk_in) disable iff (!lrst_n_reg)
    wr_byte |=> ptr_reg[ADDR_W-1:PAGE_W] == $past(ptr_reg[ADDR_W-1:PAGE_W]))
    else $error("page address changed inside page write");
  a_wp_blocks: assert property (@(posedge link_clk_in) disable iff (!lrst_n_reg)
    stop_det && wp_s2_reg && !commit_reg |=> !commit_reg)
    else $error("write started while protected");
  a_prog_bound: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    busy_reg |-> prog_cnt_reg < PROG_CNT_W'(PROG_CYCLES_P))
    else $error("programming cycle overran");
  a_prog_done: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    busy_reg && prog_last && !prog_start |=> !busy_reg)
    else $error("programming cycle did not end");

  c_start_seen: cover property (@(posedge link_clk_in) disable iff (!lrst_n_reg)
    start_det);
  c_read_byte: cover property (@(posedge link_clk_in) disable iff (!lrst_n_reg)
    ack_end && state_reg == S_READ);
  c_commit: cover property (@(posedge link_clk_in) disable iff (!lrst_n_reg)
    commit_go);
  c_prog_end: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
    busy_reg && prog_last);

endmodule

`default_nettype wire

/* File: verification/eep_master_model.sv */
// two-wire bus master model: makes scl, starts, stops and bytes
// assumes the bench resolves sda from both pull-downs and a pull-up
`timescale 1ns/1ps
`default_nettype none

module eep_master_model #(
  parameter int HALF = 80 // core cycles per scl phase
) (
  input wire logic clk_in, // timing clock
  input wire logic sda_in, // resolved sda wire level
  output logic scl_out, // serial clock, idle high
  output logic sda_low_out // high while the master pulls sda low
);
  int half = HALF; // phase length, the bench may stretch it

  // bus idle at time zero
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  // wait a number of timing clocks
  task automatic ph(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // start or repeated start: sda falls while scl high
  task automatic start();
    ph(half);
    sda_low_out <= 1'b0;
    ph(half);
    scl_out <= 1'b1;
    ph(half);
    sda_low_out <= 1'b1;
    ph(half);
    scl_out <= 1'b0;
  endtask

  // stop: sda rises while scl high, bus left idle
  task automatic stop();
    ph(half);
    sda_low_out <= 1'b1;
    ph(half);
    scl_out <= 1'b1;
    ph(half);
    sda_low_out <= 1'b0;
    ph(half);
  endtask

  // one bit: sda set mid low phase, sampled at the end of high
  task automatic bit_xfer(input logic b, output logic r);
    ph(half / 2);
    sda_low_out <= ~b;
    ph(half / 2);
    scl_out <= 1'b1;
    ph(half);
    r = sda_in;
    scl_out <= 1'b0;
  endtask

  // send a byte msb first, return the receiver's acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask

  // receive a byte, then acknowledge if more are wanted
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(~more, r);
  endtask
endmodule

`default_nettype wire

/* File: verification/eep_two_wire_slave_tb.sv */
// self-checking bench for the two-wire eeprom slave
// assumes eep_master_model as bus master and a pulled-up sda wire
`timescale 1ns/1ps
`default_nettype none

module eep_two_wire_slave_tb;
  import eep_pkg::*;
  localparam int PROG_SIM = 2000; // shortened programming time
  localparam logic [3:0] DEV = 4'h5; // arbitrary type code value
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp = 1'b0;
  logic [2:0] dsel = 3'h0;
  logic scl, sda_low, sda, sda_o, sda_oe, busy, standby, ack;
  logic [7:0] rd;
  int busy_cnt = 0;
  int busy_base = 0;
  int miscompares = 0;
  int check_count = 0;

  // wired-and sda with pull-up
  assign sda = ~((sda_oe === 1'b1) | sda_low);

  // clocks, unrelated in phase
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    #13;
    forever #32 link_clk = ~link_clk;
  end

  // length of the programming pulse
  always @(posedge core_clk) begin
    if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
  end

  eep_master_model u_eep_master_model (.clk_in(core_clk), .sda_in(sda), .scl_out(scl),
    .sda_low_out(sda_low));
  eep_two_wire_slave #(.PROG_CYCLES_P(PROG_SIM), .DEV_CODE(DEV)) u_eep_two_wire_slave (
    .core_clk_in(core_clk), .rst_n_in(rst_n), .link_clk_in(link_clk), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe), .wp_in(wp),
    .device_select_inputs_in(dsel), .busy_out(busy), .standby_out(standby));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // bounded wait for a level
  task automatic wait_lvl(ref logic s, input logic v, input int n);
    int k = 0;
    while (s !== v && k < n) begin
      @(posedge core_clk);
      k++;
    end
    if (s !== v) begin
      miscompares++;
      end_sim();
    end
  endtask

  // start and address byte, checking the acknowledge
  task automatic addr(input logic [2:0] blk, input logic dir, input logic exp);
    u_eep_master_model.start();
    u_eep_master_model.wbyte({DEV, blk, dir}, ack);
    check(16'(ack), 16'(exp));
  endtask

  // write bytes from a word address, then stop
  task automatic wr(input logic [2:0] blk, input logic [7:0] word, input logic [7:0] d[$]);
    addr(blk, 1'b0, 1'b1);
    u_eep_master_model.wbyte(word, ack);
    check(16'(ack), 16'h0001);
    foreach (d[i]) begin
      u_eep_master_model.wbyte(d[i], ack);
      check(16'(ack), 16'h0001);
    end
    busy_base = busy_cnt; // programming can only begin at the stop
    u_eep_master_model.stop();
  endtask

  // random read from a word address, comparing each byte
  task automatic rdchk(input logic [2:0] blk, input logic [7:0] word, input logic [7:0] e[$]);
    addr(blk, 1'b0, 1'b1);
    u_eep_master_model.wbyte(word, ack);
    addr(blk, 1'b1, 1'b1);
    foreach (e[i]) begin
      u_eep_master_model.rbyte(1'(i < e.size() - 1), rd);
      check(16'(rd), 16'(e[i]));
    end
    u_eep_master_model.stop();
  endtask

  task automatic t_reset();
    repeat (5) @(posedge link_clk);
    @(posedge core_clk);
    check(16'({sda_oe, standby, busy}), 16'h0000);
    check(16'(sda_o), 16'h0000);
    rst_n <= 1'b1;
    wait_lvl(standby, 1'b1, 200);
    $display("test reset done");
  endtask

  // partial page crossing the page end, polled while programming
  task automatic t_page();
    dsel <= 3'h7;
    wr(3'h3, 8'h0e, '{8'ha5, 8'h3c, 8'h96});
    wait_lvl(busy, 1'b1, 400);
    check(16'(standby), 16'h0000);
    addr(3'h3, 1'b0, 1'b0);
    u_eep_master_model.stop();
    wait_lvl(busy, 1'b0, PROG_SIM + 100);
    check(16'(busy_cnt - busy_base), 16'(PROG_SIM));
    wait_lvl(standby, 1'b1, 100);
    $display("test page write done");
  endtask

  // sequential read and the wrapped slot, other select inputs
  task automatic t_read();
    dsel <= 3'h0;
    rdchk(3'h3, 8'h0e, '{8'ha5, 8'h3c});
    rdchk(3'h3, 8'h00, '{8'h96});
    $display("test read back done");
  endtask

  // protected write changes nothing
  task automatic t_protect();
    wp <= 1'b1;
    wr(3'h3, 8'h0f, '{8'h11});
    repeat (600) @(posedge core_clk);
    check(16'(busy_cnt - busy_base), 16'h0000);
    wp <= 1'b0;
    rdchk(3'h3, 8'h0f, '{8'h3c});
    $display("test protect done");
  endtask

  // foreign code, then a start breaking into a byte
  task automatic t_foreign();
    u_eep_master_model.start();
    u_eep_master_model.wbyte({~DEV, 3'h3, 1'b0}, ack);
    check(16'(ack), 16'h0000);
    u_eep_master_model.stop();
    u_eep_master_model.start();
    u_eep_master_model.bit_xfer(1'b1, ack);
    u_eep_master_model.bit_xfer(1'b0, ack);
    addr(3'h3, 1'b0, 1'b1);
    u_eep_master_model.stop();
    wait_lvl(standby, 1'b1, 200);
    check(16'(busy_cnt - busy_base), 16'h0000);
    $display("test framing done");
  endtask

  initial begin
    t_reset();
    t_page();
    t_read();
    t_protect();
    t_foreign();
    end_sim();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    end_sim();
  end
endmodule

`default_nettype wire
